// >>> tb/bpsc_cell_model.sv
// Cell, charger and load as seen through the level comparators
`timescale 1ns/1ps
module bpsc_cell_model #(
  parameter int OC_DET = 4300,
  parameter int OC_REL = 4100,
  parameter int OD_DET = 2500,
  parameter int OD_REL = 2900,
  parameter int DOC_LV = 130,
  parameter int SC_LV  = 500,
  parameter int COC_LV = -125,
  parameter int DIO_LV = -700,
  parameter int ZV_LV  = 1500
) (
  input  wire logic signed [15:0] cell_mv,
  input  wire logic signed [15:0] sense_mv,
  input  wire logic signed [15:0] chg_mv,
  output bpsc_pkg::bpsc_cmp_t     cmp
);
  import bpsc_pkg::*;
  // ****************************************
  // Comparators, millivolt levels
  // ****************************************
  always_comb begin
    cmp.cell_over_ocd  = cell_mv > OC_DET;
    cmp.cell_under_ocr = cell_mv < OC_REL;
    cmp.cell_under_odd = cell_mv < OD_DET;
    cmp.cell_over_odr  = cell_mv >= OD_REL;
    cmp.sense_ge_doc   = sense_mv >= DOC_LV;
    cmp.sense_ge_short = sense_mv >= SC_LV;
    cmp.sense_lt_coc   = sense_mv < COC_LV;
    cmp.sense_lt_diode = sense_mv < DIO_LV;
    cmp.charger_ge_zv  = chg_mv >= ZV_LV;
  end
endmodule

// >>> tb/tb_bpsc_state_ctrl.sv
// Self-checking bench of the cell protection state controller
`timescale 1ns/1ps
module tb_bpsc_state_ctrl;
  import bpsc_pkg::*;
  localparam int DIV  = 4;
  localparam int LOC  = 5;
  localparam int LOD  = 4;
  localparam int LDOC = 3;
  localparam int LSC  = 2;
  localparam int LCOC = 3;
  localparam int CEIL = 5000;
  logic               pclk     = 1'b0;
  logic               presetn  = 1'b0;
  logic               psel     = 1'b0;
  logic               penable  = 1'b0;
  logic               pwrite   = 1'b0;
  logic [11:0]        paddr    = 12'h000;
  logic [31:0]        pwdata   = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic signed [15:0] cell_mv  = 16'sd3700;
  logic signed [15:0] sense_mv = 16'sd0;
  logic signed [15:0] chg_mv   = 16'sd0;
  bpsc_cmp_t          cmp;
  bpsc_sw_t           sw;
  logic [31:0]        rd;
  logic               er;
  int                 n_fail   = 0;
  int                 compares = 0;
  int                 cyc      = 0;

  bpsc_state_ctrl #(.TICK_DIV(DIV), .OC_LIM(LOC), .OD_LIM(LOD), .DOC_LIM(LDOC),
    .SC_LIM(LSC), .COC_LIM(LCOC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp(cmp), .sw(sw));
  bpsc_cell_model model_u (.cell_mv(cell_mv), .sense_mv(sense_mv), .chg_mv(chg_mv),
    .cmp(cmp));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == CEIL) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_sw(string nm, bpsc_sw_t e, bpsc_sw_t g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic bpsc_sw_t sw_of(bpsc_state_t s);
    case (s)
      ST_INIT:            return 5'h10;
      ST_NORMAL:          return 5'h18;
      ST_OVERDIS:         return 5'h14;
      ST_DOC, ST_SHORT:   return 5'h12;
      ST_ZEROV:           return 5'h11;
      default:            return 5'h08;
    endcase
  endfunction

  task automatic chk_st(bpsc_state_t s);
    apb(1'b0, STAT_OFS, 32'h0);
    chk32("status state", {29'h0, s}, {29'h0, rd[2:0]});
    chk_sw("status sw", sw_of(s), rd[8:4]);
    chk_sw("sw pins", sw_of(s), sw);
  endtask

  task automatic drive(int c, int s, int g);
    @(posedge pclk);
    cell_mv  <= 16'(c);
    sense_mv <= 16'(s);
    chg_mv   <= 16'(g);
  endtask

  task automatic wait_sw(bpsc_state_t s, int lo, int hi);
    int k;
    k = 0;
    while (sw !== sw_of(s) && k <= hi) begin
      @(posedge pclk);
      k++;
    end
    chk32("change delay in window", 32'h1, {31'h0, (k >= lo && k <= hi)});
    chk_st(s);
  endtask

  task automatic hold(bpsc_state_t s, int n);
    repeat (n) @(posedge pclk);
    chk_st(s);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk_sw("sw after reset", sw_of(ST_INIT), sw);
    chk32("ready", 32'h00000001, {31'h0, pready});
    apb(1'b0, CTRL_OFS, 32'h0);
    chk32("ctrl reset", CTRL_RST, rd);
    chk32("mapped error", 32'h0, {31'h0, er});
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk32("ctrl written", 32'h0, rd);
    apb(1'b1, STAT_OFS, 32'hFFFFFFFF);
    chk_st(ST_INIT);
    chk32("status levels", 32'h000000A0, {23'h0, rd[20:12]});
    apb(1'b0, 12'h008, 32'h0);
    chk32("unmapped error", 32'h1, {31'h0, er});
    chk32("unmapped data", 32'h0, rd);
    apb(1'b1, CTRL_OFS, CTRL_RST);
    drive(3700, 0, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    $display("test registers and start done");
    drive(4400, 0, 5000);
    hold(ST_NORMAL, 10);
    drive(3700, 0, 5000);
    drive(4400, 200, 5000);
    wait_sw(ST_OVERCHG, (LOC - 1) * DIV, (LOC + 1) * DIV + 3);
    drive(4200, 200, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    drive(4200, 0, 5000);
    drive(4200, 200, 5000);
    wait_sw(ST_DOC, (LDOC - 1) * DIV, (LDOC + 1) * DIV + 3);
    drive(3700, 0, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    $display("test overcharge and discharge over-current done");
    drive(4400, 0, 5000);
    wait_sw(ST_OVERCHG, (LOC - 1) * DIV, (LOC + 1) * DIV + 3);
    drive(4200, 0, 5000);
    hold(ST_OVERCHG, 8);
    drive(4000, 0, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    drive(4400, 0, 5000);
    wait_sw(ST_OVERCHG, (LOC - 1) * DIV, (LOC + 1) * DIV + 3);
    drive(4000, -200, 5000);
    hold(ST_OVERCHG, 8);
    drive(4000, 0, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    $display("test overcharge release done");
    drive(3700, 600, 5000);
    wait_sw(ST_SHORT, (LSC - 1) * DIV, (LSC + 1) * DIV + 3);
    drive(3700, 0, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    drive(3700, -200, 5000);
    wait_sw(ST_COC, (LCOC - 1) * DIV, (LCOC + 1) * DIV + 3);
    drive(3700, 0, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    $display("test short and charge over-current done");
    drive(2400, 200, 5000);
    wait_sw(ST_DOC, (LDOC - 1) * DIV, (LDOC + 1) * DIV + 3);
    wait_sw(ST_OVERDIS, 0, (LOD + 1) * DIV + 3);
    drive(2600, -800, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    drive(3700, 0, 5000);
    drive(2400, 0, 5000);
    wait_sw(ST_OVERDIS, (LOD - 1) * DIV, (LOD + 1) * DIV + 3);
    drive(2400, -200, 5000);
    hold(ST_OVERDIS, 24);
    drive(2600, -200, 5000);
    hold(ST_OVERDIS, 8);
    drive(3000, -200, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    drive(3700, 0, 5000);
    $display("test over-discharge done");
    drive(0, 0, 0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_st(ST_INIT);
    apb(1'b1, CTRL_OFS, 32'h0);
    drive(0, -200, 5000);
    hold(ST_INIT, 8);
    apb(1'b1, CTRL_OFS, CTRL_RST);
    wait_sw(ST_ZEROV, 0, 3);
    hold(ST_ZEROV, 24);
    drive(3000, -200, 5000);
    wait_sw(ST_NORMAL, 0, 3);
    drive(3700, 0, 5000);
    $display("test zero-volt charging done");
    report_and_stop();
  end
endmodule

// >>> verilog/bpsc_pkg.sv
// Constants, states and carriers of the cell protection state controller
package bpsc_pkg;
  // ****************************************
  // Clock and delay timing
  // ****************************************
  localparam int  CLK_HZ       = 40_000_000;
  localparam int  TICK_HZ      = 8_000;
  localparam int  TICK_DIV_DEF = (CLK_HZ + TICK_HZ - 1) / TICK_HZ;
  localparam int  DIV_W        = 13;
  localparam int  TW           = 14;
  localparam real OC_DLY_S     = 1.0;
  localparam int  OD_DLY_MS    = 64;
  localparam int  DOC_DLY_MS   = 8;
  localparam int  COC_DLY_MS   = 8;
  localparam int  SC_DLY_US    = 250;
  localparam int  OC_TICKS     = int'(OC_DLY_S * TICK_HZ);
  localparam int  OD_TICKS     = (OD_DLY_MS * TICK_HZ + 999) / 1000;
  localparam int  DOC_TICKS    = (DOC_DLY_MS * TICK_HZ + 999) / 1000;
  localparam int  COC_TICKS    = (COC_DLY_MS * TICK_HZ + 999) / 1000;
  localparam int  SC_TICKS     = (SC_DLY_US * TICK_HZ + 999_999) / 1_000_000;
  // Timer slots
  localparam int  T_OC  = 0;
  localparam int  T_OD  = 1;
  localparam int  T_DOC = 2;
  localparam int  T_SC  = 3;
  localparam int  T_COC = 4;
  localparam int  NT    = 5;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] STAT_OFS  = 12'h004;
  localparam logic [31:0] CTRL_RST  = 32'h00000001;
  localparam int          ZV_EN_BIT = 0;
  localparam int          ST_LSB    = 0;
  localparam int          SW_LSB    = 4;
  localparam int          CMP_LSB   = 12;

  // ****************************************
  // States and carriers
  // ****************************************
  typedef enum logic [2:0] {
    ST_INIT    = 3'b000,
    ST_NORMAL  = 3'b001,
    ST_OVERCHG = 3'b010,
    ST_OVERDIS = 3'b011,
    ST_DOC     = 3'b100,
    ST_SHORT   = 3'b101,
    ST_COC     = 3'b110,
    ST_ZEROV   = 3'b111
  } bpsc_state_t;

  typedef struct packed {
    logic cell_over_ocd;
    logic cell_under_ocr;
    logic cell_under_odd;
    logic cell_over_odr;
    logic sense_ge_doc;
    logic sense_ge_short;
    logic sense_lt_coc;
    logic sense_lt_diode;
    logic charger_ge_zv;
  } bpsc_cmp_t;

  typedef struct packed {
    logic charge_en;
    logic discharge_en;
    logic sense_pullup_en;
    logic sense_pulldown_en;
    logic charge_gate_hold;
  } bpsc_sw_t;
endpackage

// >>> verilog/bpsc_state_ctrl.sv
// Protection state machine, delay timers and APB register slave
// What this block does
// [R1] Normal state: cell and sense inside windows, both switches enabled.
// [R2] Cell above overcharge level for its delay: charge off, overcharge state.
// [R3] Overcharge and charge over-current states: both sense resistors off.
// [R4] Overcharge, sense in window: release when cell below release level.
// [R5] Overcharge, sense at discharge level: release when cell below detect.
// [R6] Cell above overcharge detect level blocks discharge over-current and short detection.
// [R7] Charger seen in overcharge: hold until sense rises on its removal.
// [R8] Cell below over-discharge level for delay: discharge off, pull-up on.
// [R9] Over-discharge, sense below diode level: release at detect level.
// [R10] Over-discharge, charger present, sense not below diode level: release at release level.
// [R11] Sense at discharge over-current level for delay: discharge off.
// [R12] Discharge over-current: pull-down on, pull-up off.
// [R13] Discharge over-current clears when sense falls below its level.
// [R14] Sense at short level for delay: discharge off, pull-down on.
// [R15] Over-current with cell low past over-discharge delay: over-discharge.
// [R16] Sense below charge over-current level for delay: charge off.
// [R17] Charge over-current clears when sense rises back to its level.
// [R18] No charge over-current detection in over-discharge state.
// [R19] Zero-volt charging: charge gate held on, discharge switch off.
// [R20] Zero-volt charging ends in normal at over-discharge release level.
// [R21] Zero-volt charging outranks charge over-current while cell is low.
// [R22] All delays count ticks of an 8 kHz divided clock.
// [R23] Overcharge delay is 1.0 s.
// [R24] Other delays 64 ms, 8 ms, 8 ms, 250 us; restart on condition loss.
// [R25] Start with discharge off; normal after charger puts sense in window.
`timescale 1ns/1ps
module bpsc_state_ctrl #(
  parameter int TICK_DIV  = bpsc_pkg::TICK_DIV_DEF,
  parameter int OC_LIM    = bpsc_pkg::OC_TICKS,
  parameter int OD_LIM    = bpsc_pkg::OD_TICKS,
  parameter int DOC_LIM   = bpsc_pkg::DOC_TICKS,
  parameter int SC_LIM    = bpsc_pkg::SC_TICKS,
  parameter int COC_LIM   = bpsc_pkg::COC_TICKS
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire bpsc_pkg::bpsc_cmp_t cmp,
  output bpsc_pkg::bpsc_sw_t      sw
);
  import bpsc_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  bpsc_state_t      state_r;
  bpsc_state_t      state_nxt;
  bpsc_sw_t         sw_r;
  logic             chg_seen_r;
  logic [DIV_W-1:0] div_r;
  logic             tick;
  logic [TW-1:0]    tmr_r [NT];
  logic [TW-1:0]    lim   [NT];
  logic [NT-1:0]    cond;
  logic [NT-1:0]    hit;
  logic [31:0]      ctrl_r;
  logic [31:0]      prdata_r;
  logic             zv_en;
  logic             in_win;
  logic             run_od;

  assign lim[T_OC]  = TW'(OC_LIM); // [R23]
  assign lim[T_OD]  = TW'(OD_LIM); // [R24]
  assign lim[T_DOC] = TW'(DOC_LIM);
  assign lim[T_SC]  = TW'(SC_LIM);
  assign lim[T_COC] = TW'(COC_LIM);
  assign zv_en      = ctrl_r[ZV_EN_BIT];
  assign in_win     = !cmp.sense_lt_coc && !cmp.sense_ge_doc;

  // Saturating tick counter, cleared when its condition drops
  function automatic logic [TW-1:0] tmr_step(input logic [TW-1:0] c,
                                             input logic          en,
                                             input logic          tk,
                                             input logic [TW-1:0] l);
    if (!en) begin
      return '0;
    end
    if (tk && (c < l)) begin
      return TW'(c + 1'b1);
    end
    return c;
  endfunction

  // Switch and resistor settings of each state
  function automatic bpsc_sw_t sw_of(input bpsc_state_t s);
    bpsc_sw_t o;
    o = '0;
    case (s)
      ST_INIT:    o.charge_en = 1'b1; // [R25]
      ST_NORMAL: begin
        o.charge_en    = 1'b1; // [R1]
        o.discharge_en = 1'b1;
      end
      ST_OVERCHG: o.discharge_en = 1'b1; // [R3]
      ST_OVERDIS: begin
        o.charge_en       = 1'b1;
        o.sense_pullup_en = 1'b1; // [R8]
      end
      ST_DOC, ST_SHORT: begin
        o.charge_en         = 1'b1;
        o.sense_pulldown_en = 1'b1; // [R12]
      end
      ST_COC:     o.discharge_en = 1'b1; // [R3]
      ST_ZEROV: begin
        o.charge_en        = 1'b1; // [R19]
        o.charge_gate_hold = 1'b1;
      end
      default:    o = '0;
    endcase
    return o;
  endfunction

  // ****************************************
  // Delay clock divider
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= '0;
    end else begin
      div_r <= DIV_W'(div_r + 1'b1);
    end
  end
  assign tick = (div_r == DIV_W'(TICK_DIV - 1)); // [R22]

  // ****************************************
  // Detection timers
  // ****************************************
  assign run_od = (state_r == ST_NORMAL) || (state_r == ST_DOC) ||
                  (state_r == ST_SHORT);
  always_comb begin
    cond        = '0;
    cond[T_OC]  = (state_r == ST_NORMAL) && cmp.cell_over_ocd;
    cond[T_OD]  = run_od && cmp.cell_under_odd; // [R15]
    cond[T_DOC] = (state_r == ST_NORMAL) && cmp.sense_ge_doc &&
                  !cmp.cell_over_ocd; // [R6]
    cond[T_SC]  = (state_r == ST_NORMAL) && cmp.sense_ge_short &&
                  !cmp.cell_over_ocd; // [R6]
    cond[T_COC] = (state_r == ST_NORMAL) && cmp.sense_lt_coc &&
                  !cmp.cell_under_odd; // [R18] [R21]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NT; i++) begin
        tmr_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NT; i++) begin
        tmr_r[i] <= tmr_step(tmr_r[i], cond[i], tick, lim[i]); // [R24]
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NT; i++) begin
      hit[i] = cond[i] && (tmr_r[i] == lim[i]);
    end
  end

  // ****************************************
  // Protection state machine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: begin
        if (zv_en && cmp.charger_ge_zv && cmp.cell_under_odd) begin
          state_nxt = ST_ZEROV; // [R19]
        end else if (cmp.charger_ge_zv && in_win) begin
          state_nxt = ST_NORMAL; // [R25]
        end
      end
      ST_NORMAL: begin
        if (hit[T_SC]) begin
          state_nxt = ST_SHORT; // [R14]
        end else if (hit[T_DOC]) begin
          state_nxt = ST_DOC; // [R11]
        end else if (hit[T_COC]) begin
          state_nxt = ST_COC; // [R16]
        end else if (hit[T_OD]) begin
          state_nxt = ST_OVERDIS; // [R8]
        end else if (hit[T_OC]) begin
          state_nxt = ST_OVERCHG; // [R2]
        end
      end
      ST_OVERCHG: begin
        if (chg_seen_r || cmp.sense_lt_coc) begin
          if (!cmp.sense_lt_coc && chg_seen_r) begin
            state_nxt = ST_NORMAL; // [R7]
          end
        end else if (cmp.sense_ge_doc) begin
          if (!cmp.cell_over_ocd) begin
            state_nxt = ST_NORMAL; // [R5]
          end
        end else if (cmp.cell_under_ocr) begin
          state_nxt = ST_NORMAL; // [R4]
        end
      end
      ST_OVERDIS: begin
        if (cmp.sense_lt_diode && !cmp.cell_under_odd) begin
          state_nxt = ST_NORMAL; // [R9]
        end else if (cmp.charger_ge_zv && !cmp.sense_lt_diode &&
                     cmp.cell_over_odr) begin
          state_nxt = ST_NORMAL; // [R10]
        end
      end
      ST_DOC, ST_SHORT: begin
        if (hit[T_OD]) begin
          state_nxt = ST_OVERDIS; // [R15]
        end else if (!cmp.sense_ge_doc) begin
          state_nxt = ST_NORMAL; // [R13]
        end
      end
      ST_COC: begin
        if (!cmp.sense_lt_coc) begin
          state_nxt = ST_NORMAL; // [R17]
        end
      end
      ST_ZEROV: begin
        if (cmp.cell_over_odr) begin
          state_nxt = ST_NORMAL; // [R20]
        end
      end
      default:    state_nxt = ST_INIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_r <= sw_of(ST_INIT);
    end else begin
      sw_r <= sw_of(state_nxt);
    end
  end
  assign sw = sw_r;

  // Charger seen during overcharge; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_seen_r <= 1'b0;
    end else if ((state_r == ST_OVERCHG) && cmp.sense_lt_coc) begin
      chg_seen_r <= 1'b1; // [R7]
    end else if (state_nxt != ST_OVERCHG) begin
      chg_seen_r <= 1'b0;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  assign acc      = psel && penable;
  assign hit_ctrl = (paddr == CTRL_OFS);
  assign hit_stat = (paddr == STAT_OFS);
  assign pready   = 1'b1;
  assign pslverr  = acc && !hit_ctrl && !hit_stat;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (acc && pwrite && hit_ctrl) begin
      ctrl_r <= {31'h00000000, pwdata[ZV_EN_BIT]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= '0;
      if (hit_ctrl) begin
        prdata_r <= ctrl_r;
      end else if (hit_stat) begin
        prdata_r[ST_LSB +: 3]   <= state_r;
        prdata_r[SW_LSB +: 5]   <= sw_r;
        prdata_r[CMP_LSB +: 9]  <= cmp;
      end
    end
  end
  assign prdata = prdata_r;

  // ****************************************
  // Checks
  // ****************************************
  chk_normal_both_on: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_NORMAL) |-> (sw.charge_en && sw.discharge_en))
    else $error("normal state without both switches");

  chk_oc_entry: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_NORMAL && hit[T_OC] && !(|hit[T_COC:T_OD]))
    |=> (state_r == ST_OVERCHG && !sw.charge_en))
    else $error("overcharge not entered");

  chk_oc_pulls_off: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_OVERCHG || state_r == ST_COC)
    |-> !(sw.sense_pullup_en || sw.sense_pulldown_en))
    else $error("sense resistor on in charge trip");

  chk_doc_block: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    (cmp.cell_over_ocd && $past(cmp.cell_over_ocd))
    |-> (tmr_r[T_DOC] == '0 && tmr_r[T_SC] == '0))
    else $error("over-current timer ran above overcharge level");

  chk_od_pullup: assert property ( // [R8]
    @(posedge pclk) disable iff (!presetn)
    $rose(state_r == ST_OVERDIS)
    |-> (!sw.discharge_en && sw.sense_pullup_en))
    else $error("over-discharge settings wrong");

  chk_doc_release: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_DOC && !cmp.sense_ge_doc && !hit[T_OD])
    |=> (state_r == ST_NORMAL))
    else $error("discharge over-current not released");

  chk_doc_pulls: assert property ( // [R12]
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_DOC)
    |-> (sw.sense_pulldown_en && !sw.sense_pullup_en && !sw.discharge_en))
    else $error("discharge over-current settings wrong");

  chk_coc_idle_od: assert property ( // [R18]
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_OVERDIS && $past(state_r) == ST_OVERDIS)
    |-> (tmr_r[T_COC] == '0))
    else $error("charge over-current timer ran in over-discharge");

  chk_tick_spacing: assert property ( // [R22]
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick [*2])
    else $error("delay ticks too close");

  chk_zv_gate: assert property ( // [R19]
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_ZEROV)
    |-> (sw.charge_gate_hold && sw.charge_en && !sw.discharge_en))
    else $error("zero-volt charge settings wrong");
endmodule
